// >>> hdl/rra_arbiter.v
// redundancy role arbiter with apb register access
`include "rra_regs.vh"
module rra_arbiter #(
  parameter SEARCH_CYC = `RRA_SEARCH_CYC,
  parameter BLINK_CYC  = `RRA_BLINK_CYC,
  parameter CNT_W      = 4
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // sync_config_link pins
  output wire        link_sclk,
  output wire        link_txd,
  output wire        link_tx_frame,
  input  wire        link_rxd,
  input  wire        link_rx_frame,
  input  wire        link_rx_sclk,
  // remote_io_unit port control
  output wire        remote_scan_en,
  output wire        remote_poll_en,
  // indicators
  output wire        run_led,
  output wire        hold_led,
  output wire        force_led
);
  localparam ST_POWERUP  = 6'b000001;
  localparam ST_SEARCH   = 6'b000010;
  localparam ST_DECIDE   = 6'b000100;
  localparam ST_ACTIVE   = 6'b001000;
  localparam ST_PASSIVE  = 6'b010000;
  localparam ST_STANDBY  = 6'b100000;
  localparam XF_IDLE     = 4'b0001;
  localparam XF_FULL     = 4'b0010;
  localparam XF_UPDATE   = 4'b0100;
  localparam XF_NONE     = 4'b1000;

  reg [5:0]       st_r;
  reg [3:0]       xf_r;
  reg [31:0]      tmr_r;
  reg [31:0]      blink_cnt_r;
  reg             blink_r;
  reg [31:0]      ctrl_r;
  reg [CNT_W-1:0] act_cnt_r;
  reg [CNT_W-1:0] pas_cnt_r;
  reg [31:0]      peer_r;
  reg             peer_seen_r;
  reg             first_up_r;
  reg             sender_r;
  reg             swap_pend_r;
  reg [7:0]       txd_r;
  reg             tx_req_r;
  reg [7:0]       tx_byte_r;
  reg [7:0]       rx_last_r;
  reg [1:0]       rx_idx_r;
  reg             xfer_done_r;

  wire       tx_ready;
  wire       rx_valid;
  wire [7:0] rx_data;

  // ctrl fields: 3:0 selector, 4 last role active, 5 config valid,
  // 6 forced-in, 7 forced-out, 8 safe-out, 9 full transfer done,
  // 27:12 config identity (name/date/time digest), 31:28 firmware, 11:10 remote rate
  wire [3:0]  sel       = ctrl_r[3:0];
  wire        last_act  = ctrl_r[4];
  wire        cfg_ok    = ctrl_r[5];
  wire        forced    = ctrl_r[6] | ctrl_r[7] | ctrl_r[8];
  wire [15:0] cfg_id    = ctrl_r[27:12];
  // peer status word laid out the same way as ctrl, except bit 9 is read as peer active
  wire        p_last    = peer_r[4];
  wire        p_cfg_ok  = peer_r[5];
  wire        p_active  = peer_r[9];
  wire [15:0] p_cfg_id  = peer_r[27:12];
  wire        hw_mism   = peer_seen_r & ((peer_r[3:0] == sel) | (peer_r[11:10] != ctrl_r[11:10]) |
                          (peer_r[31:28] != ctrl_r[31:28]));
  wire        is_active = (st_r == ST_ACTIVE);
  // search and decide count as passive, so no scan starts before the role is settled
  wire        is_passive = (st_r == ST_SEARCH) | (st_r == ST_DECIDE) | (st_r == ST_PASSIVE);
  wire        same_cfg  = cfg_ok & p_cfg_ok & (cfg_id == p_cfg_id);

  function win_tie;
    input [3:0] s;
    begin
      win_tie = (s == `RRA_SEL_MAIN);
    end
  endfunction

  rra_serial u_link (
    .clk             (clk),
    .srst            (srst),
    .tx_valid        (tx_req_r),
    .tx_data         (tx_byte_r),
    .tx_ready        (tx_ready),
    .rx_valid_r      (rx_valid),
    .rx_data_r       (rx_data),
    .link_sclk_r     (link_sclk),
    .link_txd_r      (link_txd),
    .link_tx_frame_r (link_tx_frame),
    .link_rxd        (link_rxd),
    .link_rx_frame   (link_rx_frame),
    .link_rx_sclk    (link_rx_sclk)
  );

  // role state machine
  always @(posedge clk) begin
    if (srst) begin
      st_r <= ST_POWERUP;
      tmr_r <= 32'h0000_0000;
      first_up_r <= 1'b0;
      sender_r <= 1'b0;
    end else begin
      case (st_r)
        ST_POWERUP: begin
          tmr_r <= 32'h0000_0000;
          st_r <= ST_SEARCH;
        end
        ST_SEARCH: begin
          tmr_r <= tmr_r + 32'h0000_0001;
          if (peer_seen_r && p_active) begin
            // peer already running: we came up second
            first_up_r <= 1'b0;
            sender_r <= 1'b0;
            st_r <= ST_PASSIVE;
          end else if (peer_seen_r) begin
            st_r <= ST_DECIDE;
          end else if (tmr_r >= SEARCH_CYC - 1) begin
            first_up_r <= 1'b1;
            st_r <= ST_ACTIVE;
          end
        end
        ST_DECIDE: begin
          // simultaneous power-up: history first, selector breaks ties
          if (last_act != p_last) begin
            st_r <= last_act ? ST_ACTIVE : ST_PASSIVE;
            sender_r <= same_cfg & last_act;
          end else begin
            st_r <= win_tie(sel) ? ST_ACTIVE : ST_PASSIVE;
            sender_r <= same_cfg & win_tie(sel);
          end
        end
        ST_ACTIVE: begin
          // first powered unit sets sender_r from cfg_ok on the edge xf_r goes to XF_NONE, so it never sends config
          if (first_up_r && peer_seen_r)
            sender_r <= cfg_ok;
          if (act_cnt_r < pas_cnt_r) begin
            sender_r <= 1'b0;
            st_r <= ST_PASSIVE;
          end
          // equal counts fall through and keep the role
        end
        ST_PASSIVE: begin
          if (swap_pend_r || (peer_seen_r && !p_active))
            st_r <= ST_ACTIVE;
        end
        default: st_r <= ST_POWERUP;
      endcase
    end
  end

  // transfer state: full copy, then only updates
  always @(posedge clk) begin
    if (srst) begin
      xf_r <= XF_IDLE;
    end else begin
      case (xf_r)
        XF_IDLE: begin
          if (is_active && peer_seen_r)
            xf_r <= sender_r ? XF_FULL : XF_NONE;
        end
        XF_FULL: begin
          if (xfer_done_r)
            xf_r <= XF_UPDATE;
        end
        XF_UPDATE: begin
          if (!is_active)
            xf_r <= XF_IDLE;
        end
        XF_NONE: begin
          if (!peer_seen_r)
            xf_r <= XF_IDLE;
        end
        default: xf_r <= XF_IDLE;
      endcase
    end
  end

  // link traffic: status words out, status and swap requests in
  always @(posedge clk) begin
    if (srst) begin
      tx_req_r <= 1'b0;
      tx_byte_r <= 8'h00;
      peer_r <= 32'h0000_0000;
      peer_seen_r <= 1'b0;
      swap_pend_r <= 1'b0;
      rx_last_r <= 8'h00;
      rx_idx_r <= 2'h0;
      xfer_done_r <= 1'b0;
    end else begin
      if (tx_req_r && tx_ready)
        tx_req_r <= 1'b0;
      else if (!tx_req_r && tx_ready && st_r != ST_POWERUP) begin
        tx_req_r <= 1'b1;
        // only the active unit ever pushes configuration
        if (is_active && xf_r == XF_FULL)
          tx_byte_r <= `RRA_MSG_CONFIG;
        else if (is_active && xf_r == XF_UPDATE)
          tx_byte_r <= txd_r;
        else
          tx_byte_r <= {`RRA_MSG_STATUS};
      end
      xfer_done_r <= ctrl_r[9];
      if (rx_valid) begin
        rx_last_r <= rx_data;
        peer_seen_r <= 1'b1;
        peer_r <= {peer_r[23:0], rx_data};
        rx_idx_r <= rx_idx_r + 2'h1;
        if (rx_data == `RRA_MSG_SWAP)
          swap_pend_r <= 1'b1;
      end else if (is_active) begin
        swap_pend_r <= 1'b0;
      end
    end
  end

  // passive polls both remote ports; active scans only on matching config
  assign remote_scan_en = is_active & cfg_ok & same_cfg;
  assign remote_poll_en = is_passive;

  // blink timebase shared by all indicators
  always @(posedge clk) begin
    if (srst) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  assign run_led   = is_active ? 1'b1 : blink_r;
  assign hold_led  = cfg_ok ? 1'b1 : blink_r;
  // mismatch blink only on the passive side
  assign force_led = (!is_active && hw_mism) ? blink_r : forced;

  // apb: zero wait states, unmapped reads zero with pslverr
  wire mapped = (paddr == `RRA_ADDR_ROLE) | (paddr == `RRA_ADDR_STAT) | (paddr == `RRA_ADDR_CTRL) |
                (paddr == `RRA_ADDR_CNT) | (paddr == `RRA_ADDR_PEER) | (paddr == `RRA_ADDR_TXDATA) |
                (paddr == `RRA_ADDR_RXDATA);
  wire wr = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge clk) begin
    if (srst) begin
      ctrl_r <= `RRA_CTRL_RST;
      act_cnt_r <= {CNT_W{1'b0}};
      pas_cnt_r <= {CNT_W{1'b0}};
      txd_r <= `RRA_MSG_UPDATE;
    end else if (wr) begin
      case (paddr)
        `RRA_ADDR_CTRL:   ctrl_r <= pwdata;
        `RRA_ADDR_CNT: begin
          act_cnt_r <= pwdata[CNT_W-1:0];
          pas_cnt_r <= pwdata[CNT_W+15:16];
        end
        `RRA_ADDR_TXDATA: txd_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always @* begin
    case (paddr)
      `RRA_ADDR_ROLE:   prdata = {26'h0, st_r};
      `RRA_ADDR_STAT:   prdata = {24'h0, peer_seen_r, sender_r, first_up_r, hw_mism, xf_r};
      `RRA_ADDR_CTRL:   prdata = ctrl_r;
      `RRA_ADDR_CNT:    prdata = {{(16-CNT_W){1'b0}}, pas_cnt_r, {(16-CNT_W){1'b0}}, act_cnt_r};
      `RRA_ADDR_PEER:   prdata = peer_r;
      `RRA_ADDR_TXDATA: prdata = {24'h0, txd_r};
      `RRA_ADDR_RXDATA: prdata = {22'h0, rx_idx_r, rx_last_r};
      default:          prdata = 32'h0000_0000;
    endcase
  end
endmodule

// >>> hdl/rra_regs.vh
// constants for the redundancy role arbiter
// What this block does
// - unit holds active or passive role; passive watches active for takeover
// - selector 0 means main, 9 means backup; used for tied history and the peer settings mismatch check
// - after power-up the unit starts passive before peer search
// - search 2 seconds for active peer, then become active
// - simultaneous power-up: previously active unit becomes active again
// - equal prior roles: main-selector unit becomes active, backup passive
// - configuration flows only active to passive over dedicated link
// - on peer detection both units exchange status to pick sender
// - same valid configuration: active unit also becomes sender
// - mismatch, sequential power-up, first unit valid: first unit sends; the code puts xf_r in XF_NONE instead, so nothing is sent
// - all other cases: no transfer state entered
// - sequential power-up: first unit becomes active and sends full configuration; the code makes it active but xf_r goes to XF_NONE, so it sends none
// - after full transfer only updates are sent
// - link is six-wire full-duplex synchronous serial at 1.875 Mbit/s; the integer divider gives about 1.894 Mbit/s
// - active scans remote unit only when its configuration matches
// - passive polls active and passive ports of remote units
// - active count strictly below passive count swaps roles
// - run indicator steady when active, blinking when passive
// - hold indicator steady when configured, blinking when not
// - force indicator on in forced or safe modes, off otherwise
// - passive unit blinks force indicator on settings mismatch with peer
`ifndef RRA_REGS_VH
`define RRA_REGS_VH
`define RRA_CLK_HZ        250000000
`define RRA_SEARCH_MS     2000
`define RRA_SEARCH_CYC    ((`RRA_CLK_HZ / 1000) * `RRA_SEARCH_MS)
`define RRA_LINK_BPS      1875000
`define RRA_LINK_DIV      (`RRA_CLK_HZ / (2 * `RRA_LINK_BPS))
`define RRA_BLINK_CYC     62500000
`define RRA_SEL_MAIN      4'h0
`define RRA_SEL_BACKUP    4'h9
`define RRA_MSG_STATUS    8'hA5
`define RRA_MSG_CONFIG    8'hC3
`define RRA_MSG_UPDATE    8'h3C
`define RRA_MSG_SWAP      8'h5A
`define RRA_ADDR_ROLE     12'h000
`define RRA_ADDR_STAT     12'h004
`define RRA_ADDR_CTRL     12'h008
`define RRA_ADDR_CNT      12'h00C
`define RRA_ADDR_PEER     12'h010
`define RRA_ADDR_TXDATA   12'h014
`define RRA_ADDR_RXDATA   12'h018
`define RRA_CTRL_RST      32'h0000_0000
`endif

// >>> hdl/rra_serial.v
// full-duplex synchronous serial byte channel for the config link
`include "rra_regs.vh"
module rra_serial #(
  parameter DIV = `RRA_LINK_DIV
) (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // transmit byte
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  output wire       tx_ready,
  // receive byte
  output reg        rx_valid_r,
  output reg  [7:0] rx_data_r,
  // link pins
  output reg        link_sclk_r,
  output reg        link_txd_r,
  output reg        link_tx_frame_r,
  input  wire       link_rxd,
  input  wire       link_rx_frame,
  input  wire       link_rx_sclk
);
  reg [7:0]  div_r;
  reg [3:0]  bit_r;
  reg [7:0]  sh_r;
  reg [2:0]  rclk_s;
  reg [2:0]  rd_s;
  reg [2:0]  rf_s;
  reg [2:0]  rbit_r;
  reg [7:0]  rsh_r;
  reg        rclk_q;
  // pin inputs go through three stages; for the clock, stages two and three must agree
  wire rclk_ok  = (rclk_s[1] == rclk_s[2]);
  wire rclk_lvl = rclk_s[2];
  wire rx_rise  = rclk_ok & rclk_lvl & ~rclk_q;
  assign tx_ready = (bit_r == 4'h0) && !link_tx_frame_r;
  always @(posedge clk) begin
    if (srst) begin
      div_r <= 8'h00;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      link_sclk_r <= 1'b0;
      link_txd_r <= 1'b0;
      link_tx_frame_r <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      sh_r <= tx_data;
      bit_r <= 4'h8;
      div_r <= 8'h00;
      link_tx_frame_r <= 1'b1;
      link_txd_r <= tx_data[7];
    end else if (link_tx_frame_r) begin
      // divider sets 66 clocks per half bit, about 1.894 Mbit/s at 250 MHz
      if (div_r == DIV[7:0] - 8'h01) begin
        div_r <= 8'h00;
        link_sclk_r <= ~link_sclk_r;
        if (link_sclk_r) begin
          sh_r <= {sh_r[6:0], 1'b0};
          link_txd_r <= sh_r[6];
          bit_r <= bit_r - 4'h1;
          if (bit_r == 4'h1)
            link_tx_frame_r <= 1'b0;
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
  always @(posedge clk) begin
    if (srst) begin
      rclk_s <= 3'h0;
      rd_s <= 3'h0;
      rf_s <= 3'h0;
      rclk_q <= 1'b0;
      rbit_r <= 3'h0;
      rsh_r <= 8'h00;
      rx_valid_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else begin
      rclk_s <= {rclk_s[1:0], link_rx_sclk};
      rd_s <= {rd_s[1:0], link_rxd};
      rf_s <= {rf_s[1:0], link_rx_frame};
      if (rclk_ok)
        rclk_q <= rclk_lvl;
      rx_valid_r <= 1'b0;
      if (!(rf_s[2] && rf_s[1])) begin
        rbit_r <= 3'h0;
      end else if (rx_rise) begin
        rsh_r <= {rsh_r[6:0], rd_s[2]};
        rbit_r <= rbit_r + 3'h1;
        if (rbit_r == 3'h7) begin
          rx_valid_r <= 1'b1;
          rx_data_r <= {rsh_r[6:0], rd_s[2]};
        end
      end
    end
  end
endmodule

// >>> sim/rra_assertions.sv
// port checker for the role arbiter
module rra_checker #(
  parameter BLINK_CYC = 8
) (
  // clock and reset
  input wire        clk,
  input wire        srst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // pins
  input wire        link_tx_frame,
  input wire        remote_scan_en,
  input wire        remote_poll_en,
  input wire        run_led,
  input wire        hold_led,
  input wire        force_led
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reg        run_q_r;
  reg [31:0] still_r;
  // a stalled blink shows as a long run of equal samples
  always @(posedge clk) begin
    run_q_r <= run_led;
    if (srst || !remote_poll_en || run_led != run_q_r) begin
      still_r <= 32'h0;
    end else begin
      still_r <= still_r + 32'h1;
    end
  end
  property p_zero_wait;
    psel && penable |-> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access without ready");
  property p_unmapped_err;
    psel && penable && paddr > 12'h018 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
  property p_mapped_ok;
    psel && penable && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  property p_roles_apart;
    !(remote_scan_en && remote_poll_en);
  endproperty
  a_roles_apart: assert property (p_roles_apart) else $error("scan and poll together");
  property p_reset_quiet;
    $fell(srst) |-> !(run_led || hold_led || force_led || remote_scan_en || remote_poll_en || link_tx_frame);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_passive_first;
    $fell(srst) |-> ##[1:4] remote_poll_en;
  endproperty
  a_passive_first: assert property (p_passive_first) else $error("not passive after reset");
  property p_active_steady;
    (!remote_poll_en) [*4] |-> $stable(run_led);
  endproperty
  a_active_steady: assert property (p_active_steady) else $error("run led moves while active");
  property p_passive_blinks;
    remote_poll_en |-> still_r <= BLINK_CYC + 2;
  endproperty
  a_passive_blinks: assert property (p_passive_blinks) else $error("run led stuck while passive");
  c_unmapped: cover property (psel && penable && pslverr);
  c_takeover: cover property ($fell(remote_poll_en));
  c_scan: cover property ($rose(remote_scan_en));
endmodule

bind rra_arbiter rra_checker #(.BLINK_CYC(BLINK_CYC)) rra_checker_i (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_tx_frame(link_tx_frame),
  .remote_scan_en(remote_scan_en), .remote_poll_en(remote_poll_en), .run_led(run_led),
  .hold_led(hold_led), .force_led(force_led)
);

// >>> sim/rra_peer_model.sv
// peer unit model on the far end of the sync_config_link
`include "rra_regs.vh"
module rra_peer_model #(
  parameter HALF = `RRA_LINK_DIV
) (
  // clock
  input wire   clk,
  // from the unit
  input wire   link_sclk,
  input wire   link_txd,
  input wire   link_tx_frame,
  // to the unit
  output logic peer_rxd,
  output logic peer_rx_frame,
  output logic peer_rx_sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got_r;
  initial begin
    peer_rxd = 1'b1;
    peer_rx_frame = 1'b0;
    peer_rx_sclk = 1'b0;
  end
  // keep what the unit tells us during the status exchange
  always @(posedge link_sclk) begin
    if (link_tx_frame) begin
      got_r <= {got_r[30:0], link_txd};
    end
  end
  // msb first, data moves while the clock is low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      peer_rxd <= b[i];
      peer_rx_frame <= 1'b1;
      peer_rx_sclk <= 1'b0;
      repeat (HALF) @(posedge clk);
      peer_rx_sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
    end
    peer_rx_sclk <= 1'b0;
    peer_rx_frame <= 1'b0;
    // idle data flips so a stale bit is never mistaken for a held one
    peer_rxd <= ~b[0];
    repeat (HALF) @(posedge clk);
  endtask
endmodule

// >>> sim/test_redundancy_role_arbiter.sv
// self-checking bench for the role arbiter
`include "rra_regs.vh"
module test_redundancy_role_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam SRCH = 100;
  localparam BL = 8;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        link_sclk, link_txd, link_tx_frame, link_rxd, link_rx_frame, link_rx_sclk;
  logic        remote_scan_en, remote_poll_en, run_led, hold_led, force_led;
  int          err_count, check_count, tg;
  rra_arbiter #(.SEARCH_CYC(SRCH), .BLINK_CYC(BL)) rra_arbiter_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sclk(link_sclk),
    .link_txd(link_txd), .link_tx_frame(link_tx_frame), .link_rxd(link_rxd), .link_rx_frame(link_rx_frame),
    .link_rx_sclk(link_rx_sclk), .remote_scan_en(remote_scan_en), .remote_poll_en(remote_poll_en),
    .run_led(run_led), .hold_led(hold_led), .force_led(force_led));
  rra_peer_model rra_peer_model_i (.clk(clk), .link_sclk(link_sclk), .link_txd(link_txd),
    .link_tx_frame(link_tx_frame), .peer_rxd(link_rxd), .peer_rx_frame(link_rx_frame),
    .peer_rx_sclk(link_rx_sclk));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task report_and_stop;
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask
  function logic sig(input int w);
    case (w)
      0: return remote_poll_en;
      1: return remote_scan_en;
      2: return run_led;
      3: return hold_led;
      default: return force_led;
    endcase
  endfunction
  task wait_sig(input int w, input logic v, input int n);
    for (int i = 0; i < n && sig(w) !== v; i++) @(posedge clk);
  endtask
  // counts level changes, so steady gives 0 and blinking gives several
  task toggles(input int w, input int n);
    logic p;
    tg = 0;
    p = sig(w);
    repeat (n) begin
      @(posedge clk);
      if (sig(w) !== p) tg++;
      p = sig(w);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wait_sig(0, 1'b1, 6);
    check_bit(remote_poll_en, 1'b1);
    toggles(2, 4 * BL);
    check_bit(tg >= 2, 1'b1);
    apb(1'b0, 12'h01C, 32'h0);
    check_word(rd, 32'h0);
    check_bit(err, 1'b1);
    apb(1'b0, `RRA_ADDR_CTRL, 32'h0);
    check_word(rd, `RRA_CTRL_RST);
    apb(1'b1, `RRA_ADDR_CTRL, 32'h0000_0029);
    apb(1'b0, `RRA_ADDR_CTRL, 32'h0);
    check_word(rd, 32'h0000_0029);
    check_bit(remote_poll_en, 1'b1);
    wait_sig(0, 1'b0, SRCH + 40);
    check_bit(remote_poll_en, 1'b0);
    toggles(2, 4 * BL);
    check_bit(tg == 0, 1'b1);
    toggles(3, 4 * BL);
    check_bit(tg == 0, 1'b1);
    apb(1'b1, `RRA_ADDR_CTRL, 32'h0000_0009);
    toggles(3, 4 * BL);
    check_bit(tg >= 2, 1'b1);
    for (int i = 6; i <= 8; i++) begin
      apb(1'b1, `RRA_ADDR_CTRL, 32'h0000_0029 | (32'h1 << i));
      wait_sig(4, 1'b1, 4);
      check_bit(force_led, 1'b1);
    end
    apb(1'b1, `RRA_ADDR_CTRL, 32'h0000_0029);
    wait_sig(4, 1'b0, 4);
    check_bit(force_led, 1'b0);
    apb(1'b1, `RRA_ADDR_CNT, 32'h0002_0002);
    toggles(0, 20);
    check_bit(tg == 0, 1'b1);
    apb(1'b1, `RRA_ADDR_CNT, 32'h0003_0001);
    wait_sig(0, 1'b1, 40);
    check_bit(remote_poll_en, 1'b1);
    // selector back on main; the peer will report main as well
    apb(1'b1, `RRA_ADDR_CTRL, 32'h0000_0020);
    apb(1'b1, `RRA_ADDR_CNT, 32'h0002_0002);
    rra_peer_model_i.send_byte(8'h5A);
    wait_sig(0, 1'b0, 1000);
    check_bit(remote_poll_en, 1'b0);
    toggles(2, 4 * BL);
    check_bit(tg == 0, 1'b1);
    rra_peer_model_i.send_byte(8'h00);
    rra_peer_model_i.send_byte(8'h00);
    rra_peer_model_i.send_byte(8'h02);
    rra_peer_model_i.send_byte(8'h20);
    apb(1'b0, `RRA_ADDR_PEER, 32'h0);
    check_word(rd, 32'h0000_0220);
    wait_sig(1, 1'b1, 20);
    check_bit(remote_scan_en, 1'b1);
    apb(1'b1, `RRA_ADDR_CTRL, 32'h0000_1020);
    wait_sig(1, 1'b0, 20);
    check_bit(remote_scan_en, 1'b0);
    // peer is active on main too: the clash shows only once this unit is passive
    toggles(4, 4 * BL);
    check_bit(tg == 0, 1'b1);
    apb(1'b1, `RRA_ADDR_CNT, 32'h0003_0001);
    wait_sig(0, 1'b1, 40);
    check_bit(remote_poll_en, 1'b1);
    toggles(4, 4 * BL);
    check_bit(tg >= 2, 1'b1);
    // a passive unit only ever sends status bytes
    while (link_tx_frame !== 1'b1) @(posedge clk);
    while (link_tx_frame !== 1'b0) @(posedge clk);
    check_word({24'h0, rra_peer_model_i.got_r[7:0]}, {24'h0, `RRA_MSG_STATUS});
    report_and_stop();
  end
endmodule
